/* sync_serial_port_map.vh */
// constants shared by the synchronous serial port design
`ifndef SYNC_SERIAL_PORT_MAP_VH
`define SYNC_SERIAL_PORT_MAP_VH

// ****************************************************************
// clock and bit-rate limits
// ****************************************************************
`define CLK_SYS_HZ        50000000
`define MAX_BAUD_HZ       8000000
// least half bit period in clock cycles, rounded up
`define MIN_HALF_CYC      ((`CLK_SYS_HZ + 2 * `MAX_BAUD_HZ - 1) / (2 * `MAX_BAUD_HZ))
// smallest reload that the divider will accept
`define MIN_RELOAD        (16'h0000 + `MIN_HALF_CYC - 1)

// ****************************************************************
// word format
// ****************************************************************
`define WORD_W            16
`define WIDTH_CODE_MIN    4'h1
`define RX_RESET_VAL      16'h0000
`define TX_IDLE_VAL       16'h0000

`endif

/* hs_baud_gen.v */
// reloadable 16-bit divider producing half-bit ticks for the serial clock
`include "sync_serial_port_map.vh"

module hs_baud_gen (
    // clock and reset
    input  wire        clk_sys,
    input  wire        rstn,
    // control
    input  wire        run,      // count only while a word is shifting
    input  wire [15:0] reload,   // divider reload value
    // tick out
    output reg         tick_ff   // one-cycle pulse every max(reload, MIN_RL)+1 cycles
);

    reg  [15:0] cnt_ff;          // down counter
    reg  [15:0] eff_reload;      // reload after the rate ceiling
    // floor worked out at full width, then cut to the counter width
    localparam [31:0] MIN_RL_W = `MIN_RELOAD;
    localparam [15:0] MIN_RL   = MIN_RL_W[15:0];

    // ****************************************************************
    // rate ceiling: small reloads are raised so the link never exceeds
    // the top bit rate; this also covers the reserved zero value
    // ****************************************************************
    always @* begin
        if (reload < MIN_RL) begin // see R8
            eff_reload = MIN_RL;
        end else begin
            eff_reload = reload;
        end
    end

    // ****************************************************************
    // divider: one tick per reload+1 cycles, two ticks per bit
    // ****************************************************************
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_ff  <= 16'h0000;
            tick_ff <= 1'b0;
        end else if (!run) begin
            // hold at the reload so the first half bit is full length
            cnt_ff  <= eff_reload;
            tick_ff <= 1'b0;
        end else if (cnt_ff == 16'h0000) begin
            cnt_ff  <= eff_reload; // see R7
            tick_ff <= 1'b1;       // see R11
        end else begin
            cnt_ff  <= cnt_ff - 16'h0001;
            tick_ff <= 1'b0;
        end
    end

endmodule

/* sync_serial_port.v */
// two independent synchronous serial ports and their shift engine
`include "sync_serial_port_map.vh"

// ****************************************************************
// one serial port: shift engine, buffers and pin control
// ****************************************************************
module hs_sync_port_n (
    // clock and reset
    input  wire        clk_sys,
    input  wire        rstn,
    // configuration
    input  wire        en,          // port enable
    input  wire        master,      // 1: drive the shift clock
    input  wire        half_duplex, // 1: data line is open drain
    input  wire        cpol,        // idle level of the shift clock
    input  wire        cpha,        // 1: sample on the trailing edge
    input  wire        lsb_first,   // shift direction
    input  wire [3:0]  width_code,  // bits per word minus one, code 0 acts as 1
    input  wire [15:0] reload,      // baud divider reload
    // transmit buffer
    input  wire [15:0] tx_data,
    input  wire        tx_wr,       // one-cycle write strobe
    output reg         tx_full_ff,
    // receive buffer
    output reg  [15:0] rx_data_ff,
    output reg         rx_valid_ff,
    input  wire        rx_ack,      // one-cycle read strobe
    output reg         overrun_ff,
    output reg         busy_ff,
    // pins
    input  wire        sclk_in,
    output reg         sclk_out_ff,
    output reg         sclk_oe_n_ff,
    input  wire        sd_in,
    output reg         sd_out_ff,
    output reg         sd_oe_n_ff,
    input  wire        sel_n        // slave select, active low
);

    localparam [1:0] ST_IDLE  = 2'b01;
    localparam [1:0] ST_SHIFT = 2'b10;

    reg  [1:0]  state_ff;      // engine state
    reg  [15:0] tx_buf_ff;     // queued word
    reg  [15:0] tx_sh_ff;      // transmit shifter
    reg  [15:0] rx_sh_ff;      // receive shifter
    reg  [4:0]  cnt_ff;        // bits sampled so far
    reg  [2:0]  sclk_s_ff;     // clock synchroniser plus edge stage
    reg  [1:0]  sd_s_ff;       // data synchroniser
    reg  [1:0]  sel_s_ff;      // select synchroniser
    wire        tick;          // half-bit tick from divider
    reg  [3:0]  w;             // msb index of the word
    reg  [4:0]  nbits;         // bits per word
    reg         lead_ev;       // clock leaves idle level
    reg         trail_ev;      // clock returns to idle level
    reg         sample_ev;
    reg         shift_ev;
    reg  [15:0] rx_next;
    reg  [15:0] tx_next;
    reg  [4:0]  cnt_next;
    reg         done_ev;       // word complete
    reg         load_ev;       // take the queued word
    reg  [15:0] load_val;
    reg         out_bit;
    integer     i;

    // ****************************************************************
    // pin synchronisers: the second stage feeds all logic
    // ****************************************************************
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sclk_s_ff <= 3'h0;
            sd_s_ff   <= 2'h0;
            sel_s_ff  <= 2'h3;
        end else begin
            sclk_s_ff <= {sclk_s_ff[1:0], sclk_in};
            sd_s_ff   <= {sd_s_ff[0], sd_in};
            sel_s_ff  <= {sel_s_ff[0], sel_n};
        end
    end

    hs_baud_gen u_baud (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .run     (master && (state_ff == ST_SHIFT)),
        .reload  (reload),
        .tick_ff (tick)
    );

    // ****************************************************************
    // edge events and shifter next values
    // ****************************************************************
    always @* begin
        if (width_code < `WIDTH_CODE_MIN) begin
            w = `WIDTH_CODE_MIN;
        end else begin
            w = width_code;
        end
        nbits = {1'b0, w} + 5'h01;
        // master edges come from its own clock, slave edges from the pin
        if (master) begin // see R3
            lead_ev  = tick && (sclk_out_ff == cpol);
            trail_ev = tick && (sclk_out_ff != cpol);
        end else begin
            lead_ev  = (sclk_s_ff[1] != sclk_s_ff[2]) && (sclk_s_ff[2] == cpol);
            trail_ev = (sclk_s_ff[1] != sclk_s_ff[2]) && (sclk_s_ff[1] == cpol);
        end
        lead_ev   = lead_ev && (state_ff == ST_SHIFT);
        trail_ev  = trail_ev && (state_ff == ST_SHIFT);
        // phase picks which edge samples and which edge shifts
        sample_ev = cpha ? trail_ev : lead_ev;          // see R4
        shift_ev  = (cpha ? lead_ev : trail_ev) && (cnt_ff != 5'h00);
        // receive shifter, both directions
        rx_next = rx_sh_ff;
        if (sample_ev) begin
            if (lsb_first) begin // see R4
                for (i = 0; i < 16; i = i + 1) begin
                    if (i == w) begin
                        rx_next[i] = sd_s_ff[1];
                    end else if (i < w) begin
                        rx_next[i] = rx_sh_ff[i + 1];
                    end else begin
                        rx_next[i] = 1'b0;
                    end
                end
            end else begin
                // bits above the word stay clear, as in lsb first
                rx_next = {rx_sh_ff[14:0], sd_s_ff[1]} & ~(16'hfffe << w);
            end
        end
        cnt_next = sample_ev ? cnt_ff + 5'h01 : cnt_ff;
        // master ends on the tick that returns the clock idle; slave at last sample
        if (master) begin
            done_ev = trail_ev && (cnt_next == nbits);
        end else begin
            done_ev = sample_ev && (cnt_next == nbits);
        end
        // transmit shifter
        tx_next = tx_sh_ff;
        if (shift_ev) begin
            tx_next = lsb_first ? (tx_sh_ff >> 1) : (tx_sh_ff << 1);
        end
        // load: master needs a queued word, slave loads on selection
        load_ev = 1'b0;
        if (en && (state_ff == ST_IDLE)) begin
            load_ev = master ? tx_full_ff : !sel_s_ff[1];
        end else if (en && !master && done_ev && !sel_s_ff[1]) begin
            load_ev = 1'b1;
        end
        // an empty buffer sends the idle pattern
        load_val = tx_full_ff ? tx_buf_ff : `TX_IDLE_VAL;
        if (load_ev) begin
            tx_next = load_val;
        end
        out_bit = lsb_first ? tx_next[0] : tx_next[w];
    end

    // ****************************************************************
    // engine: state, shifters and clock pin
    // ****************************************************************
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_ff     <= ST_IDLE;
            tx_sh_ff     <= 16'h0000;
            rx_sh_ff     <= 16'h0000;
            cnt_ff       <= 5'h00;
            sclk_out_ff  <= 1'b0;
            sclk_oe_n_ff <= 1'b1;
            sd_out_ff    <= 1'b1;
            sd_oe_n_ff   <= 1'b1;
            busy_ff      <= 1'b0;
        end else begin
            tx_sh_ff <= tx_next;
            rx_sh_ff <= rx_next;
            sd_out_ff <= out_bit;
            // master drives the clock, slave releases it
            sclk_oe_n_ff <= !(en && master); // see R3
            // half duplex drives only zeros so lines can be shared
            if (!en || (!master && sel_s_ff[1])) begin
                sd_oe_n_ff <= 1'b1;
            end else if (half_duplex) begin // see R2
                sd_oe_n_ff <= out_bit;
            end else begin
                sd_oe_n_ff <= 1'b0;
            end
            case (state_ff)
                ST_IDLE: begin
                    sclk_out_ff <= cpol; // see R5
                    cnt_ff      <= 5'h00;
                    if (load_ev) begin
                        state_ff <= ST_SHIFT;
                        busy_ff  <= 1'b1;
                    end
                end
                ST_SHIFT: begin
                    if (master && tick) begin
                        sclk_out_ff <= !sclk_out_ff;
                    end
                    if (!en || (!master && sel_s_ff[1])) begin
                        // disable, or deselect of a slave, abandons the word
                        state_ff <= ST_IDLE;
                        busy_ff  <= 1'b0;
                    end else if (done_ev && !load_ev) begin
                        state_ff <= ST_IDLE;
                        busy_ff  <= 1'b0;
                        cnt_ff   <= 5'h00;
                    end else if (done_ev) begin
                        cnt_ff <= 5'h00;
                    end else begin
                        cnt_ff <= cnt_next;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                    busy_ff  <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // double buffers: a write or an arriving word wins over the clear
    // ****************************************************************
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tx_buf_ff   <= 16'h0000;
            tx_full_ff  <= 1'b0;
            rx_data_ff  <= `RX_RESET_VAL;
            rx_valid_ff <= 1'b0;
            overrun_ff  <= 1'b0;
        end else begin
            if (tx_wr) begin
                tx_buf_ff  <= tx_data;
                tx_full_ff <= 1'b1;          // see R6
            end else if (load_ev) begin
                tx_full_ff <= 1'b0;
            end
            if (done_ev) begin
                rx_data_ff  <= rx_next;      // see R6
                rx_valid_ff <= 1'b1;
                // an unread word lost to a newer one
                overrun_ff  <= rx_valid_ff && !rx_ack;
            end else if (rx_ack) begin
                rx_valid_ff <= 1'b0;
                overrun_ff  <= 1'b0;
            end
        end
    end

endmodule

// ****************************************************************
// top: two identical, independent serial ports
// ****************************************************************
// Notes on behaviour
// R1: two identical independent serial ports
// R2: full duplex, or half duplex sharing lines
// R3: master drives shift clock, slave receives it
// R4: programmable width, bit order, polarity, phase
// R5: framing compatible with SPI devices
// R6: transmit and receive each double buffered
// R7: own 16-bit reloadable baud generator
// R8: bit rate never above 8 Mbaud
// R9: software avoids reload 0, 1 above 32MHz
// R10: software uses reload 2 only up to 48MHz
// R11: bit rate is clock over 2(reload+1); reloads below 3 are raised to 3, giving clock over 8
module sync_serial_port (
    // clock and reset
    input  wire        clk_sys,
    input  wire        rstn,
    // port 0 configuration
    input  wire        p0_en,
    input  wire        p0_master,
    input  wire        p0_half_duplex,
    input  wire        p0_cpol,
    input  wire        p0_cpha,
    input  wire        p0_lsb_first,
    input  wire [3:0]  p0_width_code,
    input  wire [15:0] p0_reload,
    // port 0 data
    input  wire [15:0] p0_tx_data,
    input  wire        p0_tx_wr,
    output wire        p0_tx_full,
    output wire [15:0] p0_rx_data,
    output wire        p0_rx_valid,
    input  wire        p0_rx_ack,
    output wire        p0_overrun,
    output wire        p0_busy,
    // port 0 pins
    input  wire        p0_sclk_in,
    output wire        p0_sclk_out,
    output wire        p0_sclk_oe_n,
    input  wire        p0_sd_in,
    output wire        p0_sd_out,
    output wire        p0_sd_oe_n,
    input  wire        p0_sel_n,
    // port 1 configuration
    input  wire        p1_en,
    input  wire        p1_master,
    input  wire        p1_half_duplex,
    input  wire        p1_cpol,
    input  wire        p1_cpha,
    input  wire        p1_lsb_first,
    input  wire [3:0]  p1_width_code,
    input  wire [15:0] p1_reload,
    // port 1 data
    input  wire [15:0] p1_tx_data,
    input  wire        p1_tx_wr,
    output wire        p1_tx_full,
    output wire [15:0] p1_rx_data,
    output wire        p1_rx_valid,
    input  wire        p1_rx_ack,
    output wire        p1_overrun,
    output wire        p1_busy,
    // port 1 pins
    input  wire        p1_sclk_in,
    output wire        p1_sclk_out,
    output wire        p1_sclk_oe_n,
    input  wire        p1_sd_in,
    output wire        p1_sd_out,
    output wire        p1_sd_oe_n,
    input  wire        p1_sel_n
);

    // both ports share nothing but the clock and reset
    hs_sync_port_n hs_sync_port_0 ( // see R1
        .clk_sys (clk_sys), .rstn (rstn),
        .en (p0_en), .master (p0_master), .half_duplex (p0_half_duplex),
        .cpol (p0_cpol), .cpha (p0_cpha), .lsb_first (p0_lsb_first),
        .width_code (p0_width_code), .reload (p0_reload),
        .tx_data (p0_tx_data), .tx_wr (p0_tx_wr), .tx_full_ff (p0_tx_full),
        .rx_data_ff (p0_rx_data), .rx_valid_ff (p0_rx_valid),
        .rx_ack (p0_rx_ack), .overrun_ff (p0_overrun), .busy_ff (p0_busy),
        .sclk_in (p0_sclk_in), .sclk_out_ff (p0_sclk_out),
        .sclk_oe_n_ff (p0_sclk_oe_n), .sd_in (p0_sd_in),
        .sd_out_ff (p0_sd_out), .sd_oe_n_ff (p0_sd_oe_n),
        .sel_n (p0_sel_n)
    );

    hs_sync_port_n hs_sync_port_1 ( // see R1
        .clk_sys (clk_sys), .rstn (rstn),
        .en (p1_en), .master (p1_master), .half_duplex (p1_half_duplex),
        .cpol (p1_cpol), .cpha (p1_cpha), .lsb_first (p1_lsb_first),
        .width_code (p1_width_code), .reload (p1_reload),
        .tx_data (p1_tx_data), .tx_wr (p1_tx_wr), .tx_full_ff (p1_tx_full),
        .rx_data_ff (p1_rx_data), .rx_valid_ff (p1_rx_valid),
        .rx_ack (p1_rx_ack), .overrun_ff (p1_overrun), .busy_ff (p1_busy),
        .sclk_in (p1_sclk_in), .sclk_out_ff (p1_sclk_out),
        .sclk_oe_n_ff (p1_sclk_oe_n), .sd_in (p1_sd_in),
        .sd_out_ff (p1_sd_out), .sd_oe_n_ff (p1_sd_oe_n),
        .sel_n (p1_sel_n)
    );

endmodule

/* sync_serial_port_sva.sv */
// checker for buffer and shift clock behaviour at the port pins
module sync_serial_port_sva (
    // clock and reset
    input wire        clk_sys,
    input wire        rstn,
    // port 0, run as master
    input wire        p0_en,
    input wire        p0_master,
    input wire        p0_cpol,
    input wire [15:0] p0_reload,
    input wire        p0_tx_wr,
    input wire        p0_tx_full,
    input wire        p0_rx_valid,
    input wire        p0_rx_ack,
    input wire        p0_overrun,
    input wire        p0_busy,
    input wire        p0_sclk_out,
    input wire        p0_sclk_oe_n,
    input wire        p0_half_duplex,
    input wire        p0_sd_out,
    input wire        p0_sd_oe_n,
    // port 1, run as slave
    input wire        p1_master,
    input wire        p1_sclk_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // ********************************
    // helper state
    // ********************************
    logic [1:0]  settle_ff; // edges since reset, saturating
    logic        last_ff;   // clock pin one edge ago
    logic [15:0] gap_ff;    // edges since the last clock toggle
    logic        inword_ff; // a toggle already seen in this word
    logic [15:0] half;      // expected half bit in cycles
    logic        tog;       // clock pin moved at the last edge
    assign tog = p0_sclk_out != last_ff;
    // low reloads are clamped so the rate stays under its ceiling
    assign half = (p0_reload < 16'h0003) ? 16'h0004 : p0_reload + 16'h0001;
    // settle counter keeps checks away from values seen in reset
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            settle_ff <= 2'h0;
            last_ff   <= 1'b0;
            gap_ff    <= 16'h0000;
            inword_ff <= 1'b0;
        end else begin
            settle_ff <= (settle_ff == 2'h3) ? 2'h3 : settle_ff + 2'h1;
            last_ff   <= p0_sclk_out;
            gap_ff    <= tog ? 16'h0001 : gap_ff + 16'h0001;
            inword_ff <= p0_busy & (inword_ff | tog);
        end
    end
    a_half_period: assert property (
        p0_busy && inword_ff && tog |-> gap_ff == half)
        else $error("shift clock half period off");
    a_tx_full_set: assert property (
        p0_tx_wr |=> p0_tx_full)
        else $error("tx buffer write not held");
    a_load_start: assert property (
        settle_ff == 2'h3 && p0_en && p0_master && p0_tx_full && !p0_busy
        |=> p0_busy)
        else $error("queued word not started");
    a_valid_hold: assert property (
        p0_rx_valid && !p0_rx_ack |=> p0_rx_valid)
        else $error("received word lost before read");
    a_ack_clears: assert property (
        p0_rx_ack && !p0_busy |=> !p0_rx_valid && !p0_overrun)
        else $error("read strobe did not clear flags");
    a_overrun_set: assert property (
        p0_rx_valid && !p0_rx_ack && p0_busy ##1 !p0_busy |-> p0_overrun)
        else $error("overrun not flagged");
    a_sclk_idle: assert property (
        settle_ff == 2'h3 && p0_en && p0_master && !p0_busy
        && !$past(p0_busy) && $stable(p0_cpol) |-> p0_sclk_out == p0_cpol)
        else $error("idle clock level wrong");
    a_master_drives: assert property (
        settle_ff == 2'h3 && $past(p0_en) && $past(p0_master)
        |-> !p0_sclk_oe_n)
        else $error("master not driving clock");
    a_sd_drive: assert property (
        settle_ff == 2'h3 && $past(p0_en) && $past(p0_master)
        |-> p0_sd_oe_n == ($past(p0_half_duplex) && p0_sd_out))
        else $error("data pin drive wrong");
    a_slave_quiet: assert property (
        settle_ff == 2'h3 && !p1_master |-> p1_sclk_oe_n)
        else $error("slave drives the clock pin");
endmodule

bind sync_serial_port sync_serial_port_sva chk_i (.*);

/* far_spi_slave.sv */
// far-side serial slave model facing the master port
module far_spi_slave (
    // serial lines
    input  wire        sclk,
    input  wire        sel_n,     // active low, from the bench
    input  wire        mosi,
    output logic       miso,
    // frame format, set to match the port
    input  wire        cpol,
    input  wire        cpha,
    input  wire        lsb_first,
    input  wire [4:0]  nbits,
    // data
    input  wire [15:0] reply,
    output logic [15:0] got
);
    timeunit 1ns;
    timeprecision 1ns;
    // ********************************
    // behaviour
    // ********************************
    int si; // next bit to capture
    int oi; // next bit to send
    function automatic int pos(input int i);
        return lsb_first ? i : nbits - 1 - i;
    endfunction
    initial begin
        miso = 1'b1;
        got  = 16'h0000;
        si   = 0;
        oi   = 0;
    end
    // phase 0 needs its first bit out before any clock edge
    always @(negedge sel_n) begin
        si  = 0;
        oi  = 0;
        got = 16'h0000;
        if (!cpha) begin
            miso = reply[pos(0)];
            oi   = 1;
        end
    end
    // a released line shows the inverse so a stale bit cannot pass
    always @(posedge sel_n) miso = ~miso;
    // counters wrap so words may follow under one selection
    always @(sclk) begin
        if (!sel_n) begin
            if ((sclk != cpol) ^ cpha) begin
                got[pos(si)] = mosi;
                si = (si + 1) % nbits;
            end else begin
                miso = reply[pos(oi)];
                oi = (oi + 1) % nbits;
            end
        end
    end
endmodule

/* tb.sv */
// self-checking bench: master port to far model, slave port listening
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ********************************
    // stimulus, wiring and checks
    // ********************************
    logic        clk_sys, rstn, en, cpol, cpha, lsb_first, sel_n, hd;
    logic        tx_wr, ack0, ack1;
    logic [3:0]  width_code;
    logic [15:0] reload, tx_data, reply;
    wire         p0_tx_full, p0_rx_valid, p0_overrun, p0_busy;
    wire         p0_sclk_out, p0_sd_out, p0_sd_in, p1_rx_valid;
    wire  [15:0] p0_rx_data, p1_rx_data, far_got;
    wire  [4:0]  nbits;
    int          n_fail, num_checks;
    // code 0 still gives a two-bit word
    assign nbits = (width_code == 4'h0) ? 5'h02 : {1'b0, width_code} + 5'h01;
    sync_serial_port sync_serial_port_i (.clk_sys(clk_sys), .rstn(rstn),
        .p0_en(en), .p0_master(1'b1), .p0_half_duplex(hd), .p0_cpol(cpol),
        .p0_cpha(cpha), .p0_lsb_first(lsb_first), .p0_width_code(width_code),
        .p0_reload(reload), .p0_tx_data(tx_data), .p0_tx_wr(tx_wr),
        .p0_tx_full(p0_tx_full), .p0_rx_data(p0_rx_data),
        .p0_rx_valid(p0_rx_valid), .p0_rx_ack(ack0), .p0_overrun(p0_overrun),
        .p0_busy(p0_busy), .p0_sclk_in(p0_sclk_out), .p0_sclk_out(p0_sclk_out),
        .p0_sclk_oe_n(), .p0_sd_in(p0_sd_in), .p0_sd_out(p0_sd_out),
        .p0_sd_oe_n(), .p0_sel_n(sel_n),
        .p1_en(en), .p1_master(1'b0), .p1_half_duplex(1'b0), .p1_cpol(cpol),
        .p1_cpha(cpha), .p1_lsb_first(lsb_first), .p1_width_code(width_code),
        .p1_reload(reload), .p1_tx_data(16'h0000), .p1_tx_wr(1'b0),
        .p1_tx_full(), .p1_rx_data(p1_rx_data), .p1_rx_valid(p1_rx_valid),
        .p1_rx_ack(ack1), .p1_overrun(), .p1_busy(), .p1_sclk_in(p0_sclk_out),
        .p1_sclk_out(), .p1_sclk_oe_n(), .p1_sd_in(p0_sd_out), .p1_sd_out(),
        .p1_sd_oe_n(), .p1_sel_n(sel_n));
    far_spi_slave far_spi_slave_i (.sclk(p0_sclk_out), .sel_n(sel_n),
        .mosi(p0_sd_out), .miso(p0_sd_in), .cpol(cpol), .cpha(cpha),
        .lsb_first(lsb_first), .nbits(nbits), .reply(reply), .got(far_got));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        if (n_fail == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // format changes only while nothing is selected
    task automatic cfg(input logic [3:0] m, input logic [3:0] wc,
                       input logic [15:0] rl);
        {lsb_first, cpha, cpol} = m[2:0];
        width_code = wc;
        reload = rl;
        repeat (4) @(negedge clk_sys);
    endtask
    // one word each way; select leads so the slave sync settles first
    task automatic xfer(input logic [15:0] w, input logic [15:0] rp);
        logic [15:0] msk;
        logic        s;
        int          n;
        msk = 16'hffff >> (16 - nbits);
        reply = rp;
        sel_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        tx_data = w;
        tx_wr = 1'b1;
        @(negedge clk_sys);
        tx_wr = 1'b0;
        n = 0;
        while (p0_sclk_out === cpol && n < 99) begin
            @(negedge clk_sys);
            n++;
        end
        s = p0_sclk_out;
        n = 0;
        while (p0_sclk_out === s && n < 99) begin
            @(negedge clk_sys);
            n++;
        end
        chk(n[15:0], (reload < 16'h0003) ? 16'h0004 : reload + 16'h0001);
        n = 0;
        while (p0_rx_valid !== 1'b1 && n < 999) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 999) n_fail++;
        chk(p0_rx_data, rp & msk);
        chk(far_got, w & msk);
        n = 0;
        while (p1_rx_valid !== 1'b1 && n < 30) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 30) n_fail++;
        chk(p1_rx_data, w & msk);
        ack0 = 1'b1;
        ack1 = 1'b1;
        @(negedge clk_sys);
        ack0 = 1'b0;
        ack1 = 1'b0;
        sel_n = 1'b1;
        chk({15'h0000, p0_rx_valid}, 16'h0000);
        repeat (4) @(negedge clk_sys);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // whole run needs well under 10000 cycles
    initial begin
        #400000;
        n_fail++;
        finish_test;
    end
    initial begin
        int n;
        n_fail = 0;
        num_checks = 0;
        {rstn, en, cpol, cpha, lsb_first, tx_wr, ack0, ack1} = 8'h40;
        hd = 1'b0;
        sel_n = 1'b1;
        width_code = 4'h7;
        {reload, tx_data, reply} = {16'h0003, 16'h0000, 16'h0000};
        repeat (4) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (4) @(negedge clk_sys);
        // every polarity, phase and order
        for (int m = 0; m < 8; m++) begin
            cfg(m[3:0], 4'h7, 16'h0003);
            xfer(16'h00a5 + m[15:0], 16'h003c - m[15:0]);
        end
        // reserved reload: the clamp must hold the rate ceiling
        cfg(4'h3, 4'hf, 16'h0000);
        xfer(16'hc3a5, 16'h5e71);
        // open-drain data pin, then a push-pull two-bit word at reload 2
        hd = 1'b1;
        cfg(4'h6, 4'h1, 16'h0007);
        xfer(16'h0002, 16'h0001);
        hd = 1'b0;
        cfg(4'h1, 4'h0, 16'h0002);
        xfer(16'h0001, 16'h0002);
        // second word queued while the first shifts, nothing read
        cfg(4'h0, 4'h7, 16'h0003);
        reply = 16'h0096;
        sel_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        tx_data = 16'h0011;
        tx_wr = 1'b1;
        @(negedge clk_sys);
        tx_data = 16'h00e7;
        @(negedge clk_sys);
        tx_wr = 1'b0;
        @(negedge clk_sys);
        chk({15'h0000, p0_tx_full}, 16'h0001);
        n = 0;
        while (p0_overrun !== 1'b1 && n < 999) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 999) n_fail++;
        chk(p0_rx_data, 16'h0096);
        chk(far_got, 16'h00e7);
        repeat (20) @(negedge clk_sys);
        chk(p1_rx_data, 16'h00e7);
        sel_n = 1'b1;
        ack0 = 1'b1;
        @(negedge clk_sys);
        ack0 = 1'b0;
        chk({15'h0000, p0_overrun}, 16'h0000);
        finish_test;
    end
endmodule
